// ===== src/pgdc_top.v
// deviation counter with electronic gear, clear logic and axi4-lite registers
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pgdc_defines.vh"
// Overview of operation
// - clear pin low forces deviation to zero
// - clear pin low suspends position loop output
// - servo off keeps pulses unless auto clear
// - mode 0 clears on servo off only
// - mode 1 never clears automatically
// - mode 2 clears on off/overtravel, not clamp
// - width select picks 16 or 32 bit gear
// - short gear 1..65535, default 1, on restart
// - long value is high*10000 plus low
// - gear ratio must stay 0.01 to 100; outside it is only flagged in status, not limited
// - each reference pulse is one reference unit
// - reference unit scaled by b over a
module pgdc_top (
    clock,
    reset_n,
    clock_en,
    ref_step,
    ref_dir,
    deviation_clear_n,
    overtravel,
    fb_step,
    fb_dir,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    deviation_count,
    loop_enable
);
    input wire clock;
    input wire reset_n;
    input wire clock_en;
    input wire ref_step;
    input wire ref_dir;
    input wire deviation_clear_n;
    input wire overtravel;
    input wire fb_step;
    input wire fb_dir;
    input wire [7:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output reg s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output reg s_axi_wready;
    output reg [1:0] s_axi_bresp;
    output reg s_axi_bvalid;
    input wire s_axi_bready;
    input wire [7:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output reg s_axi_arready;
    output reg [31:0] s_axi_rdata;
    output reg [1:0] s_axi_rresp;
    output reg s_axi_rvalid;
    input wire s_axi_rready;
    output reg signed [39:0] deviation_count;
    output reg loop_enable;

    // -----------------------------------------------------------------
    // functions
    // -----------------------------------------------------------------
    function [31:0] compose_long;
        input [13:0] high;
        input [13:0] low;
        begin
            compose_long = high * `PGDC_HALF_SCALE + {18'h00000, low};
        end
    endfunction

    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge_bytes = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_bytes[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    wire [5:0] pins_sync;
    pgdc_sync #(
        .WIDTH(6),
        .RST_VAL(6'h08)
    ) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .enable(clock_en),
        .async_in({fb_dir, fb_step, deviation_clear_n, overtravel, ref_dir, ref_step}),
        .sync_out(pins_sync)
    );
    wire ref_step_s = pins_sync[0];
    wire ref_dir_s = pins_sync[1];
    wire overtravel_s = pins_sync[2];
    wire clear_n_s = pins_sync[3];
    wire fb_step_s = pins_sync[4];
    wire fb_dir_s = pins_sync[5];
    reg ref_step_d_ff;
    reg fb_step_d_ff;
    wire ref_edge = ref_step_s & ~ref_step_d_ff;
    wire fb_edge = fb_step_s & ~fb_step_d_ff;

    // -----------------------------------------------------------------
    // parameter registers: software copies and restart-applied copies
    // -----------------------------------------------------------------
    reg [1:0] mode_ff;
    reg width_sel_ff;
    reg servo_on_ff;
    reg zclamp_ff;
    reg [15:0] num_short_ff;
    reg [15:0] den_short_ff;
    reg [13:0] num_high_ff;
    reg [13:0] num_low_ff;
    reg [13:0] den_high_ff;
    reg [13:0] den_low_ff;
    reg width_act_ff;
    reg [31:0] num_act_ff;
    reg [31:0] den_act_ff;
    reg apply_ff;
    reg ratio_bad_ff;

    // restart: new gear values come in only on reset release or apply write
    wire [31:0] num_new = width_sel_ff ? compose_long(num_high_ff, num_low_ff) : {16'h0000, num_short_ff};
    wire [31:0] den_new = width_sel_ff ? compose_long(den_high_ff, den_low_ff) : {16'h0000, den_short_ff};
    // ratio check: 100*b >= a and b <= 100*a
    wire [39:0] num_x100 = {8'h00, num_act_ff} * 40'h0000000064;
    wire [39:0] den_x100 = {8'h00, den_act_ff} * 40'h0000000064;
    wire ratio_bad = (num_x100 < {8'h00, den_act_ff}) || ({8'h00, num_act_ff} > den_x100) || (den_act_ff == 32'h0);

    // -----------------------------------------------------------------
    // clear decision
    // -----------------------------------------------------------------
    reg auto_clear;
    always @* begin
        case (mode_ff)
            `PGDC_MODE_SERVO_OFF: auto_clear = ~servo_on_ff;
            `PGDC_MODE_NEVER: auto_clear = 1'b0;
            `PGDC_MODE_BOTH: auto_clear = (~servo_on_ff | overtravel_s) & ~zclamp_ff;
            default: auto_clear = 1'b0;
        endcase
    end
    wire pin_clear = ~clear_n_s;
    wire any_clear = pin_clear | auto_clear;

    // -----------------------------------------------------------------
    // gear scaler
    // -----------------------------------------------------------------
    wire gear_valid;
    wire signed [33:0] gear_count;
    pgdc_gear #(
        .W(32)
    ) u_gear (
        .clock(clock),
        .reset_n(reset_n),
        .enable(clock_en),
        .clear(any_clear),
        .step(ref_edge),
        .dir(ref_dir_s),
        .num_b(num_act_ff),
        .den_a(den_act_ff),
        .out_valid(gear_valid),
        .out_count(gear_count)
    );

    // -----------------------------------------------------------------
    // deviation counter
    // -----------------------------------------------------------------
    wire signed [39:0] add_term = gear_valid ? {{6{gear_count[33]}}, gear_count} : 40'sh0000000000;
    wire signed [39:0] sub_term = fb_edge ? (fb_dir_s ? -40'sh0000000001 : 40'sh0000000001) : 40'sh0000000000;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            deviation_count <= 40'sh0000000000;
            loop_enable <= 1'b0;
            ref_step_d_ff <= 1'b0;
            fb_step_d_ff <= 1'b0;
        end else if (clock_en) begin
            ref_step_d_ff <= ref_step_s;
            fb_step_d_ff <= fb_step_s;
            if (any_clear) begin
                deviation_count <= 40'sh0000000000;
            end else begin
                deviation_count <= deviation_count + add_term - sub_term;
            end
            loop_enable <= ~pin_clear & servo_on_ff;
        end
    end

    // -----------------------------------------------------------------
    // axi4-lite slave
    // -----------------------------------------------------------------
    reg aw_hold_ff;
    reg w_hold_ff;
    reg [7:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire have_aw = aw_hold_ff | aw_fire;
    wire have_w = w_hold_ff | w_fire;
    wire [7:0] wr_addr = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_ff ? w_data_ff : s_axi_wdata;
    wire [3:0] wr_strb = w_hold_ff ? w_strb_ff : s_axi_wstrb;
    wire do_write = have_aw & have_w & ~s_axi_bvalid;
    wire [31:0] ctrl_word = {22'h000000, zclamp_ff, servo_on_ff, 3'h0, width_sel_ff, 2'h0, mode_ff};
    wire [31:0] wr_merged = wr_addr == `PGDC_OFS_CTRL ? merge_bytes(ctrl_word, wr_data, wr_strb) :
        merge_bytes(32'h00000000, wr_data, wr_strb);
    wire wr_hit = (wr_addr <= `PGDC_OFS_APPLY) && (wr_addr[1:0] == 2'h0) && (wr_addr != `PGDC_OFS_STATUS)
        && (wr_addr != `PGDC_OFS_DEVIATION);

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PGDC_RESP_OKAY;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            mode_ff <= `PGDC_MODE_SERVO_OFF;
            width_sel_ff <= 1'b0;
            servo_on_ff <= 1'b0;
            zclamp_ff <= 1'b0;
            num_short_ff <= `PGDC_SHORT_RST;
            den_short_ff <= `PGDC_SHORT_RST;
            num_high_ff <= `PGDC_HIGH_RST;
            num_low_ff <= `PGDC_LOW_RST;
            den_high_ff <= `PGDC_HIGH_RST;
            den_low_ff <= `PGDC_LOW_RST;
            apply_ff <= 1'b1;
            width_act_ff <= 1'b0;
            num_act_ff <= 32'h00000001;
            den_act_ff <= 32'h00000001;
            ratio_bad_ff <= 1'b0;
        end else if (clock_en) begin
            s_axi_awready <= ~have_aw & ~s_axi_bvalid;
            s_axi_wready <= ~have_w & ~s_axi_bvalid;
            apply_ff <= 1'b0;
            ratio_bad_ff <= ratio_bad;
            if (apply_ff) begin
                width_act_ff <= width_sel_ff;
                num_act_ff <= num_new;
                den_act_ff <= den_new;
            end
            if (aw_fire) begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_hold_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `PGDC_RESP_OKAY : `PGDC_RESP_SLVERR;
                case (wr_addr)
                    `PGDC_OFS_CTRL: begin
                        mode_ff <= wr_merged[`PGDC_CTRL_MODE_LSB +: 2];
                        width_sel_ff <= wr_merged[`PGDC_CTRL_WIDTH_BIT];
                        servo_on_ff <= wr_merged[`PGDC_CTRL_SERVO_ON_BIT];
                        zclamp_ff <= wr_merged[`PGDC_CTRL_ZCLAMP_BIT];
                    end
                    // zero is outside 1..max and is refused silently
                    `PGDC_OFS_NUM_SHORT: if (wr_merged[15:0] != 16'h0000) num_short_ff <= wr_merged[15:0];
                    `PGDC_OFS_DEN_SHORT: if (wr_merged[15:0] != 16'h0000) den_short_ff <= wr_merged[15:0];
                    `PGDC_OFS_NUM_HIGH: if (wr_merged[13:0] <= `PGDC_HALF_MAX) num_high_ff <= wr_merged[13:0];
                    `PGDC_OFS_NUM_LOW: if (wr_merged[13:0] <= `PGDC_HALF_MAX) num_low_ff <= wr_merged[13:0];
                    `PGDC_OFS_DEN_HIGH: if (wr_merged[13:0] <= `PGDC_HALF_MAX) den_high_ff <= wr_merged[13:0];
                    `PGDC_OFS_DEN_LOW: if (wr_merged[13:0] <= `PGDC_HALF_MAX) den_low_ff <= wr_merged[13:0];
                    `PGDC_OFS_APPLY: apply_ff <= wr_merged[0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // read channel
    reg [31:0] rd_word;
    reg rd_hit;
    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `PGDC_OFS_CTRL: rd_word = ctrl_word;
            `PGDC_OFS_NUM_SHORT: rd_word = {16'h0000, num_short_ff};
            `PGDC_OFS_DEN_SHORT: rd_word = {16'h0000, den_short_ff};
            `PGDC_OFS_NUM_HIGH: rd_word = {18'h00000, num_high_ff};
            `PGDC_OFS_NUM_LOW: rd_word = {18'h00000, num_low_ff};
            `PGDC_OFS_DEN_HIGH: rd_word = {18'h00000, den_high_ff};
            `PGDC_OFS_DEN_LOW: rd_word = {18'h00000, den_low_ff};
            `PGDC_OFS_STATUS: rd_word = {27'h0000000, width_act_ff, ratio_bad_ff, any_clear, loop_enable, pin_clear};
            `PGDC_OFS_DEVIATION: rd_word = deviation_count[31:0];
            `PGDC_OFS_APPLY: rd_word = 32'h00000000;
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PGDC_RESP_OKAY;
        end else if (clock_en) begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `PGDC_RESP_OKAY : `PGDC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // pgdc_top

// ===== src/pgdc_defines.vh
// constants for the pulse gear and deviation clear block
`ifndef PGDC_DEFINES_VH
`define PGDC_DEFINES_VH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define PGDC_OFS_CTRL 8'h00
`define PGDC_OFS_NUM_SHORT 8'h04
`define PGDC_OFS_DEN_SHORT 8'h08
`define PGDC_OFS_NUM_HIGH 8'h0C
`define PGDC_OFS_NUM_LOW 8'h10
`define PGDC_OFS_DEN_HIGH 8'h14
`define PGDC_OFS_DEN_LOW 8'h18
`define PGDC_OFS_STATUS 8'h1C
`define PGDC_OFS_DEVIATION 8'h20
`define PGDC_OFS_APPLY 8'h24
// -----------------------------------------------------------------
// control fields
// -----------------------------------------------------------------
`define PGDC_CTRL_MODE_LSB 0
`define PGDC_CTRL_WIDTH_BIT 4
`define PGDC_CTRL_SERVO_ON_BIT 8
`define PGDC_CTRL_ZCLAMP_BIT 9
`define PGDC_MODE_SERVO_OFF 2'h0
`define PGDC_MODE_NEVER 2'h1
`define PGDC_MODE_BOTH 2'h2
// -----------------------------------------------------------------
// gear limits and reset values
// -----------------------------------------------------------------
`define PGDC_SHORT_MAX 16'hFFFF
`define PGDC_SHORT_RST 16'h0001
`define PGDC_HALF_MAX 14'h270F
`define PGDC_HALF_SCALE 32'h00002710
`define PGDC_HIGH_RST 14'h0000
`define PGDC_LOW_RST 14'h0001
`define PGDC_RESP_OKAY 2'h0
`define PGDC_RESP_SLVERR 2'h2
`endif

// ===== src/pgdc_sync.v
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module pgdc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    clock,
    reset_n,
    enable,
    async_in,
    sync_out
);
    input wire clock;
    input wire reset_n;
    input wire enable;
    input wire [WIDTH-1:0] async_in;
    output wire [WIDTH-1:0] sync_out;
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else if (enable) begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
    assign sync_out = sync_ff;
endmodule // pgdc_sync

// ===== src/pgdc_gear.v
// gear scaler: one reference unit becomes b/a encoder counts with remainder carry
`timescale 1ns/1ps
module pgdc_gear #(
    parameter W = 32
) (
    clock,
    reset_n,
    enable,
    clear,
    step,
    dir,
    num_b,
    den_a,
    out_valid,
    out_count
);
    input wire clock;
    input wire reset_n;
    input wire enable;
    input wire clear;
    input wire step;
    input wire dir;
    input wire [W-1:0] num_b;
    input wire [W-1:0] den_a;
    output reg out_valid;
    output reg signed [W+1:0] out_count;
    // serial divide: accumulator holds fraction*a, whole counts emitted per pulse
    reg [W:0] rem_ff;
    reg [W:0] work_ff;
    reg [W:0] quot_ff;
    reg busy_ff;
    reg dir_ff;
    wire [W+1:0] sum = {1'b0, rem_ff} + {2'b0, num_b};
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rem_ff <= {(W+1){1'b0}};
            work_ff <= {(W+1){1'b0}};
            quot_ff <= {(W+1){1'b0}};
            busy_ff <= 1'b0;
            dir_ff <= 1'b0;
            out_valid <= 1'b0;
            out_count <= {(W+2){1'b0}};
        end else if (enable) begin
            out_valid <= 1'b0;
            if (clear) begin
                rem_ff <= {(W+1){1'b0}};
                busy_ff <= 1'b0;
            end else if (!busy_ff && step) begin
                work_ff <= sum[W:0];
                quot_ff <= {(W+1){1'b0}};
                dir_ff <= dir;
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                // ratio only flagged above 100, not limited; loop ends within about 100 cycles only while the ratio stays at most 100
                if (work_ff >= {1'b0, den_a}) begin
                    work_ff <= work_ff - {1'b0, den_a};
                    quot_ff <= quot_ff + {{W{1'b0}}, 1'b1};
                end else begin
                    rem_ff <= work_ff;
                    busy_ff <= 1'b0;
                    out_valid <= 1'b1;
                    out_count <= dir_ff ? -$signed({1'b0, quot_ff}) : $signed({1'b0, quot_ff});
                end
            end
        end
    end
endmodule // pgdc_gear

// ===== bench/pgdc_checker.sv
// concurrent checks on the gear and clear block ports
`timescale 1ns/1ps
module pgdc_checker (
    input wire clock,
    input wire reset_n,
    input wire clock_en,
    input wire deviation_clear_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire signed [39:0] deviation_count,
    input wire loop_enable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // three enabled edges cover the 2-flop sampler plus the output register
    sequence s_clr_held;
        (!deviation_clear_n && clock_en) [*3];
    endsequence
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_CLR_ZERO: assert property (s_clr_held |=> deviation_count == 40'h0)
        else $error("deviation not zero under clear");
    AST_CLR_LOOP: assert property (s_clr_held |=> !loop_enable)
        else $error("loop enabled under clear");
    AST_WR_RESP: assert property (s_wr_taken |=> s_axi_bvalid)
        else $error("no write response");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    AST_R_ERRDATA: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
endmodule // pgdc_checker
bind pgdc_top pgdc_checker u_chk (.*);

// ===== bench/pgdc_host_model.sv
// host controller model: reference pulses and clear pin
`timescale 1ns/1ps
module pgdc_host_model #(
    parameter int GAP = 20
) (
    input wire clock,
    output logic ref_step,
    output logic ref_dir,
    output logic deviation_clear_n
);
    initial begin
        ref_step = 1'b0;
        ref_dir = 1'b0;
        deviation_clear_n = 1'b1;
    end
    // direction settles one edge ahead of the step; gap exceeds ratio+3 for the ratios the bench pulses
    task automatic send_pulses(input int n, input logic dir);
        repeat (n) begin
            @(posedge clock);
            ref_dir <= dir;
            @(posedge clock);
            ref_step <= 1'b1;
            repeat (4) @(posedge clock);
            ref_step <= 1'b0;
            repeat (GAP) @(posedge clock);
        end
    endtask
    task automatic set_clear(input logic v);
        @(posedge clock);
        deviation_clear_n <= v;
    endtask
endmodule // pgdc_host_model

// ===== bench/pulse_gear_deviation_clear_test.sv
// self-checking bench for the gear and deviation clear block
`timescale 1ns/1ps
`include "pgdc_defines.vh"
`define CHK(nm, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
end
module pulse_gear_deviation_clear_test;
    logic clock, reset_n, overtravel, fb_step, fb_dir, ref_step, ref_dir, deviation_clear_n, loop_enable;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic signed [39:0] deviation_count;
    // entry: [4] cleared, [3] overtravel instead of servo off, [2] zero clamp, [1:0] clear mode
    logic [4:0] mode_tab [8] = '{5'h10, 5'h08, 5'h01, 5'h09, 5'h12, 5'h1A, 5'h0E, 5'h03};
    logic [31:0] ctrl;
    int err_total;
    int checks;
    pgdc_top uut (.*, .clock_en(1'b1));
    pgdc_host_model host (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 64) err_total++;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 64) err_total++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        `CHK("bresp", 2'h0, r)
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        `CHK($sformatf("reg %0h", a), e, d)
    endtask
    task automatic st_chk(input int b, input logic e);
        axi_read(`PGDC_OFS_STATUS, rdv, rsp);
        `CHK("status bit", e, rdv[b])
    endtask
    task automatic dev_chk(input logic [39:0] e);
        repeat (12) @(posedge clock);
        `CHK("deviation_count", e, deviation_count)
        axi_read(`PGDC_OFS_DEVIATION, rdv, rsp);
        `CHK("deviation reg", e[31:0], rdv)
    endtask
    task automatic zero_dev;
        host.set_clear(1'b0);
        repeat (5) @(posedge clock);
        host.set_clear(1'b1);
        repeat (5) @(posedge clock);
    endtask
    task automatic fb_pulses(input int n, input logic dir);
        repeat (n) begin
            fb_dir <= dir;
            @(posedge clock);
            fb_step <= 1'b1;
            repeat (4) @(posedge clock);
            fb_step <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask
    task automatic apply(input logic [31:0] c);
        wr(`PGDC_OFS_CTRL, c);
        wr(`PGDC_OFS_APPLY, 32'h1);
        repeat (2) @(posedge clock);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clock);
        err_total++;
        complete_run;
    end
    initial begin
        reset_n = 1'b0;
        overtravel = 1'b0;
        fb_step = 1'b0;
        fb_dir = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        err_total = 0;
        checks = 0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(`PGDC_OFS_CTRL, 32'h0);
        rd_chk(`PGDC_OFS_NUM_SHORT, 32'h1);
        rd_chk(`PGDC_OFS_DEN_SHORT, 32'h1);
        rd_chk(`PGDC_OFS_NUM_HIGH, 32'h0);
        rd_chk(`PGDC_OFS_NUM_LOW, 32'h1);
        rd_chk(`PGDC_OFS_DEN_HIGH, 32'h0);
        rd_chk(`PGDC_OFS_DEN_LOW, 32'h1);
        axi_read(8'h40, rdv, rsp);
        `CHK("unmapped rresp", `PGDC_RESP_SLVERR, rsp)
        axi_write(`PGDC_OFS_STATUS, 32'h1F, rsp);
        `CHK("read-only bresp", `PGDC_RESP_SLVERR, rsp)
        $display("test registers done");
        apply(32'h101);
        zero_dev;
        `CHK("loop_enable", 1'b1, loop_enable)
        host.send_pulses(3, 1'b0);
        dev_chk(40'h3);
        fb_pulses(2, 1'b0);
        dev_chk(40'h1);
        host.set_clear(1'b0);
        repeat (4) @(posedge clock);
        `CHK("loop_enable", 1'b0, loop_enable)
        host.send_pulses(1, 1'b0);
        dev_chk(40'h0);
        host.set_clear(1'b1);
        $display("test clear pin done");
        wr(`PGDC_OFS_DEN_SHORT, 32'h2);
        wr(`PGDC_OFS_NUM_SHORT, 32'h0);
        rd_chk(`PGDC_OFS_NUM_SHORT, 32'h1);
        apply(32'h101);
        zero_dev;
        host.send_pulses(3, 1'b0);
        dev_chk(40'h1);
        wr(`PGDC_OFS_NUM_SHORT, 32'h3);
        zero_dev;
        host.send_pulses(2, 1'b0);
        dev_chk(40'h1);
        apply(32'h101);
        zero_dev;
        host.send_pulses(2, 1'b0);
        dev_chk(40'h3);
        wr(`PGDC_OFS_NUM_SHORT, 32'hFFFF);
        rd_chk(`PGDC_OFS_NUM_SHORT, 32'hFFFF);
        $display("test short gear done");
        wr(`PGDC_OFS_NUM_HIGH, 32'h1);
        wr(`PGDC_OFS_NUM_LOW, 32'h2);
        wr(`PGDC_OFS_DEN_LOW, 32'h1389);
        wr(`PGDC_OFS_DEN_LOW, 32'h2710);
        rd_chk(`PGDC_OFS_DEN_LOW, 32'h1389);
        apply(32'h111);
        zero_dev;
        host.send_pulses(1, 1'b0);
        host.send_pulses(2, 1'b1);
        dev_chk(40'hFFFFFFFFFE);
        $display("test long gear done");
        wr(`PGDC_OFS_NUM_SHORT, 32'h65);
        wr(`PGDC_OFS_DEN_SHORT, 32'h1);
        apply(32'h101);
        st_chk(3, 1'b1);
        wr(`PGDC_OFS_NUM_SHORT, 32'h1);
        wr(`PGDC_OFS_DEN_SHORT, 32'h64);
        apply(32'h101);
        st_chk(3, 1'b0);
        wr(`PGDC_OFS_DEN_SHORT, 32'h1);
        apply(32'h101);
        $display("test ratio range done");
        for (int i = 0; i < 8; i++) begin
            ctrl = 32'h100 | {30'h0, mode_tab[i][1:0]} | {22'h0, mode_tab[i][2], 9'h0};
            wr(`PGDC_OFS_CTRL, ctrl);
            zero_dev;
            host.send_pulses(1, 1'b0);
            if (mode_tab[i][3]) overtravel <= 1'b1;
            else wr(`PGDC_OFS_CTRL, ctrl & 32'hFFFFFEFF);
            dev_chk(mode_tab[i][4] ? 40'h0 : 40'h1);
            overtravel <= 1'b0;
        end
        $display("test clear modes done");
        complete_run;
    end
endmodule // pulse_gear_deviation_clear_test
